// File: bench/board_model.sv
// Board strap resistors and LED loads around the shared pins
`timescale 1ns/10ps
module board_model
(
  input wire logic [2:0] strap_led_in,
  input wire logic strap_cable_in,
  input wire logic [2:0] led_pin_drive_in,
  input wire logic [2:0] led_pin_oe_n_in,
  input wire logic cable_pin_drive_in,
  input wire logic cable_pin_oe_n_in,
  output logic [2:0] led_level_out,
  output logic cable_level_out
);
  // ****************************************
  // Pin levels
  // ****************************************
  // Released pins fall back to the strap resistor; codes 001/010 only when a test asks
  assign led_level_out = (~led_pin_oe_n_in & led_pin_drive_in) | (led_pin_oe_n_in & strap_led_in);
  // Status pin has its own pull resistor
  assign cable_level_out = cable_pin_oe_n_in ? strap_cable_in : cable_pin_drive_in;
endmodule : board_model

// File: bench/tb_top.sv
// Self-checking testbench for the LED, strap and power-down block
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned HALF = 8;
  logic ref_clk_in, rst_in, soft_reset_in, cfg_duplex_col_in, cfg_speed_sd_in, power_down_input_in;
  logic rmii_select_in, link_up_in, speed_100_in, full_duplex_in, collision_in, activity_in;
  logic signal_detect_in, cable_detect_in, strap_cable;
  logic [2:0] strap_led, led_level, led_pin_out, led_pin_oe_n_out, mode_code_out;
  logic cable_level, cable_pin_out, cable_pin_oe_n_out, autoneg_en_out, adv_100_out, adv_10_out;
  logic full_duplex_cfg_out, strap_reserved_out, power_down_out, mii_quiet_out, mgmt_alive_out;
  logic use_refclk_50_out;
  int bad_count = 0;
  int n_checks = 0;
  logic [4:0] mode_exp [8] = '{5'h0C, 5'h01, 5'h01, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h1E};
  logic [4:0] mode_msk [8] = '{5'h0F, 5'h0D, 5'h0D, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F};
  logic [9:0] led_tab [5] = '{10'h2E7, 10'h295, 10'h200, 10'h1AE, 10'h361};

  // ****************************************
  // Design, board and clock
  // ****************************************
  led_strap_powerdown_ctrl #(.FLASH_HALF(HALF)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .soft_reset_in(soft_reset_in), .cfg_duplex_col_in(cfg_duplex_col_in), .cfg_speed_sd_in(cfg_speed_sd_in),
    .power_down_input_in(power_down_input_in), .rmii_select_in(rmii_select_in), .link_up_in(link_up_in),
    .speed_100_in(speed_100_in), .full_duplex_in(full_duplex_in), .collision_in(collision_in),
    .activity_in(activity_in), .signal_detect_in(signal_detect_in), .cable_detect_in(cable_detect_in),
    .led_pin_in(led_level), .cable_pin_in(cable_level), .led_pin_out(led_pin_out),
    .led_pin_oe_n_out(led_pin_oe_n_out), .cable_pin_out(cable_pin_out), .cable_pin_oe_n_out(cable_pin_oe_n_out),
    .mode_code_out(mode_code_out), .autoneg_en_out(autoneg_en_out), .adv_100_out(adv_100_out),
    .adv_10_out(adv_10_out), .full_duplex_cfg_out(full_duplex_cfg_out), .strap_reserved_out(strap_reserved_out),
    .power_down_out(power_down_out), .mii_quiet_out(mii_quiet_out), .mgmt_alive_out(mgmt_alive_out),
    .use_refclk_50_out(use_refclk_50_out));
  board_model board (.strap_led_in(strap_led), .strap_cable_in(strap_cable), .led_pin_drive_in(led_pin_out),
    .led_pin_oe_n_in(led_pin_oe_n_out), .cable_pin_drive_in(cable_pin_out), .cable_pin_oe_n_in(cable_pin_oe_n_out),
    .led_level_out(led_level), .cable_level_out(cable_level));
  // Clock at 8 ns
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // Wait for the pin enables to reach a level, bounded
  task automatic wait_oe(input logic [2:0] lvl);
    int n;
    n = 0;
    while (led_pin_oe_n_out !== lvl && n < 300)
    begin
      tick(1);
      n++;
    end
    check(8'(led_pin_oe_n_out), 8'(lvl), "pin enables");
  endtask : wait_oe
  // Once-only flash: all on, then all off
  task automatic flash_check();
    wait_oe(3'h0);
    check(8'(led_pin_out), 8'(strap_led ^ 3'h7), "flash on");
    tick(HALF + 2);
    check(8'(led_pin_out), 8'(strap_led), "flash off");
    tick(2 * HALF);
  endtask : flash_check
  task automatic do_reset(input logic [2:0] code);
    {cfg_duplex_col_in, cfg_speed_sd_in, link_up_in, speed_100_in, full_duplex_in} = 5'h00;
    {collision_in, signal_detect_in, cable_detect_in} = 3'h0;
    strap_led = code;
    strap_cable = code[0];
    rmii_select_in = code[1];
    rst_in = 1'b1;
    tick(3);
    check(8'({led_pin_oe_n_out, mii_quiet_out}), 8'h0F, "reset pins");
    rst_in = 1'b0;
    flash_check();
    check(8'(mode_code_out), 8'(code), "mode code");
  endtask : do_reset
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {rst_in, soft_reset_in, power_down_input_in, activity_in} = 4'h8;
    do_reset(3'h7);
    for (int c = 0; c < 8; c++)
    begin
      do_reset(3'(c));
      check(8'({autoneg_en_out, adv_100_out, adv_10_out, full_duplex_cfg_out, strap_reserved_out} & mode_msk[c]),
        8'(mode_exp[c] & mode_msk[c]), "mode decode");
      check(8'(use_refclk_50_out), 8'(rmii_select_in), "ref clock");
      link_up_in = 1'b1;
      cable_detect_in = strap_led[2];
      tick(3);
      check(8'({cable_pin_oe_n_out, cable_pin_out}), 8'(strap_cable ? 1'b1 : cable_detect_in), "status pin");
      for (int e = 0; e < 5; e++)
      begin
        {cfg_duplex_col_in, cfg_speed_sd_in, link_up_in, speed_100_in} = led_tab[e][9:6];
        {full_duplex_in, collision_in, signal_detect_in} = led_tab[e][5:3];
        tick(3);
        check(8'(led_pin_out), 8'(led_tab[e][2:0] ^ strap_led), "led function");
      end
    end
    // Traffic blinks the link LED off, then it comes back on
    link_up_in = 1'b1;
    activity_in = 1'b1;
    tick(1);
    activity_in = 1'b0;
    tick(3);
    check(8'(led_pin_out[2]), 8'(strap_led[2]), "activity blink");
    tick(600);
    check(8'(led_pin_out[2]), 8'(!strap_led[2]), "activity done");
    // Power-down is left only by a reset with the input low
    power_down_input_in = 1'b1;
    tick(6);
    check(8'({power_down_out, mii_quiet_out, mgmt_alive_out}), 8'h07, "power down");
    soft_reset_in = 1'b1;
    tick(4);
    soft_reset_in = 1'b0;
    tick(1);
    power_down_input_in = 1'b0;
    tick(10);
    check(8'(power_down_out), 8'h01, "stay down");
    strap_led = 3'h3;
    soft_reset_in = 1'b1;
    tick(6);
    soft_reset_in = 1'b0;
    flash_check();
    check(8'({power_down_out, mii_quiet_out, mode_code_out}), 8'h03, "wake up");
    report_and_stop();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_top

// File: hw/led_strap_if.sv
// Interface carrying sampled straps between the controller and the decoder
`timescale 1ns/10ps
interface led_strap_if;
  import led_strap_pkg::*;
  logic [2:0] mode_code;
  op_mode_t op_mode;
  modport ctl (output mode_code, input op_mode);
  modport dec (input mode_code, output op_mode);
endinterface : led_strap_if

// File: hw/led_strap_pkg.sv
// Package with constants and types for the LED, strap and power-down block
package led_strap_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ = 125000000;
  localparam int unsigned FLASH_PERIOD_MS = 500;
  localparam int unsigned FLASH_CYCLES = (CLK_FREQ_HZ / 1000) * FLASH_PERIOD_MS;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_CYCLES / 2;
  localparam int unsigned ACT_STRETCH_CYCLES = 4096;
  localparam logic [11:0] ACT_STRETCH_MAX = 12'hFFF;
  localparam int unsigned REFCLK_RMII_MHZ = 50;
  localparam int unsigned REFCLK_MII_MHZ = 25;

  // ****************************************
  // Config bit positions of the vendor control register
  // ****************************************
  localparam int unsigned CFG_REG_INDEX = 16;
  localparam int unsigned CFG_DUPLEX_COL_BIT = 5;
  localparam int unsigned CFG_SPEED_SD_BIT = 6;

  // ****************************************
  // Strap mode codes, bit2..bit0
  // ****************************************
  localparam logic [2:0] MODE_DUAL_HDX = 3'h0;
  localparam logic [2:0] MODE_RSVD1 = 3'h1;
  localparam logic [2:0] MODE_RSVD2 = 3'h2;
  localparam logic [2:0] MODE_10_HDX = 3'h3;
  localparam logic [2:0] MODE_10_FDX = 3'h4;
  localparam logic [2:0] MODE_100_HDX = 3'h5;
  localparam logic [2:0] MODE_100_FDX = 3'h6;
  localparam logic [2:0] MODE_AUTONEG_ALL = 3'h7;
  localparam logic [2:0] STRAP_RESET_VAL = 3'h7;

  // Decoded operating-mode outputs
  typedef struct packed {
    logic autoneg_en;
    logic adv_100;
    logic adv_10;
    logic full_duplex;
    logic reserved;
  } op_mode_t;

  // Controller states
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_FLASH = 4'h2,
    ST_RUN = 4'h4,
    ST_PDOWN = 4'h8
  } ctl_state_t;
endpackage : led_strap_pkg

// File: hw/led_strap_powerdown_ctrl.sv
// LED driver, reset strap capture and power-down control of a 10/100 transceiver
`timescale 1ns/10ps

module led_strap_powerdown_ctrl
  import led_strap_pkg::*;
#(
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYCLES
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic soft_reset_in,
  input wire logic cfg_duplex_col_in,
  input wire logic cfg_speed_sd_in,
  input wire logic power_down_input_in,
  input wire logic rmii_select_in,
  input wire logic link_up_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic collision_in,
  input wire logic activity_in,
  input wire logic signal_detect_in,
  input wire logic cable_detect_in,
  input wire logic [2:0] led_pin_in,
  input wire logic cable_pin_in,
  output logic [2:0] led_pin_out,
  output logic [2:0] led_pin_oe_n_out,
  output logic cable_pin_out,
  output logic cable_pin_oe_n_out,
  output logic [2:0] mode_code_out,
  output logic autoneg_en_out,
  output logic adv_100_out,
  output logic adv_10_out,
  output logic full_duplex_cfg_out,
  output logic strap_reserved_out,
  output logic power_down_out,
  output logic mii_quiet_out,
  output logic mgmt_alive_out,
  output logic use_refclk_50_out
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [2:0] pd_meta_q;
  logic pd_sync_q;
  logic soft_sync_q;
  logic rmii_sync_q;
  logic [2:0] pol_q;
  logic cable_mode_q;
  logic [2:0] mode_q;
  logic rmii_q;
  logic capture_q;
  ctl_state_t state_q;
  ctl_state_t state_d;
  logic [31:0] flash_cnt_q;
  logic flash_on_q;
  logic [11:0] act_cnt_q;
  logic [2:0] led_act;
  logic cable_val;
  led_strap_if strap_bus ();

  // Two-stage sync of strap pins and asynchronous control levels
  always_ff @(posedge ref_clk_in)
  begin
    pin_meta_q <= {cable_pin_in, led_pin_in};
    pin_sync_q <= pin_meta_q;
    pd_meta_q <= {rmii_select_in, soft_reset_in, power_down_input_in};
    pd_sync_q <= pd_meta_q[0];
    soft_sync_q <= pd_meta_q[1];
    rmii_sync_q <= pd_meta_q[2];
  end

  // ****************************************
  // Strap capture on reset release
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    // Soft reset with the power-down input high is ignored; pins are still driven then
    if (rst_in || (soft_sync_q && !pd_sync_q))
      capture_q <= 1'b1;
    else
      capture_q <= 1'b0;
  end

  // Latch straps in the cycle after reset is released
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      mode_q <= STRAP_RESET_VAL;
      pol_q <= STRAP_RESET_VAL;
      cable_mode_q <= 1'b0;
      rmii_q <= 1'b0;
    end
    else if (capture_q && !soft_sync_q)
    begin
      mode_q <= {pin_sync_q[2], pin_sync_q[1], pin_sync_q[0]};
      pol_q <= pin_sync_q[2:0];
      cable_mode_q <= pin_sync_q[3];
      rmii_q <= rmii_sync_q;
    end
  end

  assign strap_bus.mode_code = mode_q;

  strap_mode_decode u_decode (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .strap_bus(strap_bus)
  );

  // ****************************************
  // Control state machine
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = capture_q ? ST_RESET : ST_FLASH;
      ST_FLASH:
      begin
        if (pd_sync_q)
          state_d = ST_PDOWN;
        else if (flash_cnt_q >= 2 * FLASH_HALF - 1)
          state_d = ST_RUN;
      end
      ST_RUN: state_d = pd_sync_q ? ST_PDOWN : ST_RUN;
      // Only a reset leaves power-down
      ST_PDOWN: state_d = ST_PDOWN;
      default: state_d = ST_RESET;
    endcase
  end

  // State register; soft reset acts only with power-down input low
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || (soft_sync_q && !pd_sync_q))
      state_q <= ST_RESET;
    else
      state_q <= state_d;
  end

  // Flash timer: one on/off period
  always_ff @(posedge ref_clk_in)
  begin
    if (state_q != ST_FLASH)
      flash_cnt_q <= '0;
    else
      flash_cnt_q <= flash_cnt_q + 32'h1;
  end

  // Flash lamp is on for the first half period
  always_ff @(posedge ref_clk_in)
  begin
    if (state_q != ST_FLASH)
      flash_on_q <= 1'b1;
    else
      flash_on_q <= (flash_cnt_q < FLASH_HALF - 1);
  end

  // Activity stretcher so traffic is visible
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      act_cnt_q <= '0;
    else if (activity_in)
      act_cnt_q <= ACT_STRETCH_MAX;
    else if (act_cnt_q != 12'h0)
      act_cnt_q <= act_cnt_q - 12'h1;
  end

  // ****************************************
  // LED and status function
  // ****************************************
  always_comb
  begin
    led_act[0] = cfg_duplex_col_in && (full_duplex_in || collision_in);
    led_act[1] = cfg_speed_sd_in ? signal_detect_in : (link_up_in && speed_100_in);
    led_act[2] = link_up_in && (act_cnt_q[11:9] == 3'h0 || act_cnt_q[9] == 1'b0);
    if (state_q == ST_FLASH)
      led_act = {3{flash_on_q}};
    cable_val = cable_mode_q ? link_up_in : cable_detect_in;
  end

  // Pin drivers; inputs during reset, drive afterwards
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || state_q == ST_RESET)
    begin
      led_pin_oe_n_out <= 3'h7;
      cable_pin_oe_n_out <= 1'b1;
      led_pin_out <= 3'h0;
      cable_pin_out <= 1'b0;
    end
    else
    begin
      led_pin_oe_n_out <= 3'h0;
      cable_pin_oe_n_out <= 1'b0;
      led_pin_out <= led_act ^ pol_q;
      cable_pin_out <= cable_val;
    end
  end

  // Registered mode and power outputs
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      mode_code_out <= STRAP_RESET_VAL;
      autoneg_en_out <= 1'b0;
      adv_100_out <= 1'b0;
      adv_10_out <= 1'b0;
      full_duplex_cfg_out <= 1'b0;
      strap_reserved_out <= 1'b0;
      power_down_out <= 1'b0;
      mii_quiet_out <= 1'b1;
      mgmt_alive_out <= 1'b1;
      use_refclk_50_out <= 1'b0;
    end
    else
    begin
      mode_code_out <= mode_q;
      autoneg_en_out <= strap_bus.op_mode.autoneg_en;
      adv_100_out <= strap_bus.op_mode.adv_100;
      adv_10_out <= strap_bus.op_mode.adv_10;
      full_duplex_cfg_out <= strap_bus.op_mode.full_duplex;
      strap_reserved_out <= strap_bus.op_mode.reserved;
      power_down_out <= (state_q == ST_PDOWN);
      mii_quiet_out <= (state_q == ST_PDOWN) || (state_q == ST_RESET);
      mgmt_alive_out <= 1'b1;
      use_refclk_50_out <= rmii_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_pdown_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_PDOWN && !rst_in && !(soft_sync_q && !pd_sync_q) |=> state_q == ST_PDOWN)
    else $error("power-down left without reset");
  chk_pdown_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_PDOWN |=> mii_quiet_out && power_down_out && mgmt_alive_out)
    else $error("MII not quiet in power-down");
  chk_rate_indicator_output: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_RUN && !cfg_speed_sd_in |=> led_pin_out[1] == ($past(link_up_in && speed_100_in) ^ pol_q[1]))
    else $error("rate_indicator_output wrong");
  chk_cable_pin: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_RUN && cable_mode_q |=> cable_pin_out == $past(link_up_in))
    else $error("link status pin wrong");
  chk_pins_released: assert property (@(posedge ref_clk_in)
    rst_in |=> led_pin_oe_n_out == 3'h7 && cable_pin_oe_n_out)
    else $error("pins driven during reset");
  chk_flash_on: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(state_q == ST_FLASH) |=> ##1 led_pin_out == ~pol_q)
    else $error("flash did not light all LEDs");
  cov_flash_done: cover property (@(posedge ref_clk_in) state_q == ST_FLASH ##1 state_q == ST_RUN);
  cov_pdown: cover property (@(posedge ref_clk_in) state_q == ST_RUN ##1 state_q == ST_PDOWN);
  cov_soft_exit: cover property (@(posedge ref_clk_in) state_q == ST_PDOWN ##1 state_q == ST_RESET);
endmodule : led_strap_powerdown_ctrl

// File: hw/strap_mode_decode.sv
// Decoder from sampled mode-strap code to operating-mode controls
`timescale 1ns/10ps
module strap_mode_decode
  import led_strap_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  led_strap_if.dec strap_bus
);
  op_mode_t op_mode_d;
  op_mode_t op_mode_q;

  // ****************************************
  // Mode table lookup
  // ****************************************
  always_comb
  begin
    op_mode_d = '0;
    case (strap_bus.mode_code)
      MODE_AUTONEG_ALL:
      begin
        op_mode_d.autoneg_en = 1'b1;
        op_mode_d.adv_100 = 1'b1;
        op_mode_d.adv_10 = 1'b1;
        op_mode_d.full_duplex = 1'b1;
      end
      MODE_DUAL_HDX:
      begin
        op_mode_d.autoneg_en = 1'b1;
        op_mode_d.adv_100 = 1'b1;
        op_mode_d.adv_10 = 1'b1;
      end
      MODE_10_HDX: op_mode_d.adv_10 = 1'b1;
      MODE_10_FDX:
      begin
        op_mode_d.adv_10 = 1'b1;
        op_mode_d.full_duplex = 1'b1;
      end
      MODE_100_HDX: op_mode_d.adv_100 = 1'b1;
      MODE_100_FDX:
      begin
        op_mode_d.adv_100 = 1'b1;
        op_mode_d.full_duplex = 1'b1;
      end
      // Board must avoid these codes; flagged only
      default: op_mode_d.reserved = 1'b1;
    endcase
  end

  // Registered decode
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      op_mode_q <= '0;
    else
      op_mode_q <= op_mode_d;
  end

  assign strap_bus.op_mode = op_mode_q;

  chk_forced_100fdx: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    strap_bus.mode_code == MODE_100_FDX |=> op_mode_q.adv_100 && op_mode_q.full_duplex && !op_mode_q.autoneg_en)
    else $error("100 full duplex strap decoded wrongly");
  chk_all_high_an: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    strap_bus.mode_code == MODE_AUTONEG_ALL |=> op_mode_q.autoneg_en && op_mode_q.full_duplex)
    else $error("all-high strap did not enable full autoneg");
endmodule : strap_mode_decode
